// [tsr_defines.svh]
// register map, field positions, reset values and timing counts of the host
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH

`define TSR_CLK_NS 4
`define TSR_SCL_QTR_NS 2500
`define TSR_SCL_QTR_CYC ((`TSR_SCL_QTR_NS + `TSR_CLK_NS - 1) / `TSR_CLK_NS)

`define TSR_ADR_CMD 4'h0
`define TSR_ADR_WDATA 4'h4
`define TSR_ADR_STATUS 4'h8
`define TSR_ADR_RDATA 4'hC

`define TSR_CMD_GO 0
`define TSR_CMD_OP_LSB 1
`define TSR_CMD_LEN_LSB 3
`define TSR_CMD_SETPTR 5
`define TSR_CMD_PTR_LSB 8
`define TSR_CMD_SEL_LSB 12

`define TSR_ST_BUSY 0
`define TSR_ST_DONE 1
`define TSR_ST_NACK 2

`define TSR_DEV_ADDR_HI 4'h9
`define TSR_ACK_BIT 4'h8

`define TSR_PTR_TEMP 3'h0
`define TSR_PTR_CONFIG 3'h1
`define TSR_PTR_HYST 3'h2
`define TSR_PTR_OVT 3'h3
`define TSR_PTR_ONESHOT 3'h4
`define TSR_HYST_RESET 16'h4B00
`define TSR_OVT_RESET 16'h5000

`endif

// [tsr_pkg.sv]
// types shared by the sensor host modules
package tsr_pkg;
	typedef enum logic [1:0] {
		TSR_OP_PTR = 2'h0,
		TSR_OP_WRITE = 2'h1,
		TSR_OP_READ = 2'h2
	} tsr_op_e;

	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_START = 5'h02,
		S_BIT = 5'h04,
		S_STOP = 5'h08,
		S_DONE = 5'h10
	} tsr_state_e;
endpackage

// [tsr_pin_if.sv]
// carrier between the host and its pin synchroniser
`timescale 1ns/10ps
`default_nettype none
interface tsr_pin_if #(parameter int W = 2) (
	input wire logic clk,
	input wire logic rst
);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport sync (input clk, input rst, input raw, output clean);
	modport user (output raw, input clean);
endinterface
`default_nettype wire

// [tsr_pin_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module tsr_pin_sync #(
	parameter int W = 2
) (
	tsr_pin_if.sync p
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_ff, s2_ff, s3_ff, q_ff;
			// idle bus level is high, so reset there
			always_ff @(posedge p.clk) begin
				if (p.rst) begin
					s1_ff <= 1'b1;
					s2_ff <= 1'b1;
					s3_ff <= 1'b1;
					q_ff <= 1'b1;
				end else begin
					s1_ff <= p.raw[i];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
					if (s2_ff == s3_ff) begin
						q_ff <= s3_ff;
					end
				end
			end
			assign p.clean[i] = q_ff;
		end
	endgenerate
endmodule
`default_nettype wire

// [tsr_host.sv]
// sensor host: wishbone command registers driving a two-wire master
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "tsr_defines.svh"
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module tsr_host
	import tsr_pkg::*;
#(
	parameter int unsigned QTR_CYC = `TSR_SCL_QTR_CYC
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_n,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n
);
	localparam int QW = 16;
	localparam logic [QW-1:0] QTR_LAST = QW'(QTR_CYC - 1);

	tsr_state_e st_ff;
	tsr_op_e op_ff;
	logic [1:0] ph_ff, byte_ff, len_ff;
	logic [3:0] bit_ff;
	logic [2:0] tot_ff, ptr_ff, sel_ff;
	logic [7:0] sh_ff;
	logic [15:0] wdata_ff, rdata_ff;
	logic [QW-1:0] qcnt_ff;
	logic rd_ff, pend_rd_ff, setptr_ff, go_ff, nak_ff;
	logic done_ff, nack_ff, ev_nack_ff;
	logic wb_ack_ff;
	logic [31:0] wb_dat_ff;
	logic scl_oe_n_ff, sda_oe_n_ff, pin_lvl_ff;
	logic nxt_scl_rel, nxt_sda_rel;
	logic sda_s, scl_s, tick, stretch, busy, host_rx, last_byte;
	logic wb_req, wb_wr, st_clr;

	assign wb_dat_o = wb_dat_ff;
	assign wb_ack_o = wb_ack_ff;
	assign scl_oe_n = scl_oe_n_ff;
	assign sda_oe_n = sda_oe_n_ff;
	assign scl_o = pin_lvl_ff;
	assign sda_o = pin_lvl_ff;

	////////////////////////////////////////////////////////////////////////
	// pins pass the three-stage filter before any use
	tsr_pin_if #(.W(2)) pins (.clk(core_clk), .rst(reset));
	assign pins.raw = {scl_i, sda_i};
	tsr_pin_sync #(.W(2)) u_sync (.p(pins.sync));
	assign sda_s = pins.clean[0];
	assign scl_s = pins.clean[1];

	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] byte_of(input logic [1:0] idx,
		input logic rd, input logic [2:0] sel, input logic [2:0] ptr,
		input logic [15:0] wd);
		case (idx)
			2'h0: byte_of = {`TSR_DEV_ADDR_HI, sel, rd};
			2'h1: byte_of = {5'h00, ptr};
			2'h2: byte_of = wd[15:8];
			default: byte_of = wd[7:0];
		endcase
	endfunction

	// bytes in one start-to-stop part, address byte included
	function automatic logic [2:0] part_len(input logic rd,
		input tsr_op_e op, input logic [1:0] len);
		if (rd) begin
			part_len = 3'h1 + {1'b0, len};
		end else if (op == TSR_OP_WRITE) begin
			part_len = 3'h2 + {1'b0, len};
		end else begin
			part_len = 3'h2;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// wishbone slave: answer one cycle after the request
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_ff;
	assign wb_wr = wb_req && wb_we_i;
	assign busy = (st_ff != S_IDLE) || go_ff;
	assign st_clr = wb_wr && (wb_adr_i == `TSR_ADR_STATUS) && wb_sel_i[0];

	always_ff @(posedge core_clk) begin
		if (reset) begin
			wb_ack_ff <= 1'b0;
		end else begin
			wb_ack_ff <= wb_req;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			wb_dat_ff <= 32'h0000_0000;
		end else if (wb_req && !wb_we_i) begin
			case (wb_adr_i)
				`TSR_ADR_CMD: wb_dat_ff <= {17'h00000, sel_ff, 1'b0, ptr_ff,
					2'h0, setptr_ff, len_ff, op_ff, 1'b0};
				`TSR_ADR_WDATA: wb_dat_ff <= {16'h0000, wdata_ff};
				`TSR_ADR_STATUS: wb_dat_ff <= {29'h0000_0000, nack_ff,
					done_ff, busy};
				`TSR_ADR_RDATA: wb_dat_ff <= {16'h0000, rdata_ff};
				default: wb_dat_ff <= 32'h0000_0000;
			endcase
		end
	end

	// commands and data are frozen while a transfer runs
	always_ff @(posedge core_clk) begin
		if (reset) begin
			op_ff <= TSR_OP_PTR;
			len_ff <= 2'h0;
			setptr_ff <= 1'b0;
			ptr_ff <= `TSR_PTR_TEMP;
			sel_ff <= 3'h0;
			go_ff <= 1'b0;
		end else begin
			go_ff <= 1'b0;
			if (wb_wr && (wb_adr_i == `TSR_ADR_CMD) &&
				(wb_sel_i[1:0] == 2'h3) && !busy) begin
				case (wb_dat_i[`TSR_CMD_OP_LSB +: 2])
					2'h1: op_ff <= TSR_OP_WRITE;
					2'h2: op_ff <= TSR_OP_READ;
					default: op_ff <= TSR_OP_PTR;
				endcase
				// a limit holds two bytes, so longer bursts are clamped
				if (wb_dat_i[`TSR_CMD_LEN_LSB +: 2] == 2'h3) begin
					len_ff <= 2'h2;
				end else begin
					len_ff <= wb_dat_i[`TSR_CMD_LEN_LSB +: 2];
				end
				setptr_ff <= wb_dat_i[`TSR_CMD_SETPTR];
				ptr_ff <= wb_dat_i[`TSR_CMD_PTR_LSB +: 3];
				sel_ff <= wb_dat_i[`TSR_CMD_SEL_LSB +: 3];
				go_ff <= wb_dat_i[`TSR_CMD_GO];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			wdata_ff <= 16'h0000;
		end else if (wb_wr && (wb_adr_i == `TSR_ADR_WDATA) && !busy) begin
			if (wb_sel_i[0]) begin
				wdata_ff[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				wdata_ff[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	// a new event beats a clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (reset) begin
			done_ff <= 1'b0;
			nack_ff <= 1'b0;
		end else begin
			done_ff <= (st_ff == S_DONE) ||
				(done_ff && !(st_clr && wb_dat_i[`TSR_ST_DONE]));
			nack_ff <= ev_nack_ff ||
				(nack_ff && !(st_clr && wb_dat_i[`TSR_ST_NACK]));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// quarter-period divider; a slave holding clock low stalls it
	assign stretch = scl_oe_n_ff && !scl_s;
	assign tick = (qcnt_ff == QTR_LAST) && !stretch;

	always_ff @(posedge core_clk) begin
		if (reset || (st_ff == S_IDLE)) begin
			qcnt_ff <= {QW{1'b0}};
		end else if (tick) begin
			qcnt_ff <= {QW{1'b0}};
		end else if (!stretch) begin
			qcnt_ff <= qcnt_ff + {{(QW-1){1'b0}}, 1'b1};
		end
	end

	assign host_rx = rd_ff && (byte_ff != 2'h0);
	assign last_byte = (({1'b0, byte_ff} + 3'h1) == tot_ff);

	////////////////////////////////////////////////////////////////////////
	// data moves in the second low quarter, clear of the falling clock
	always_comb begin
		nxt_scl_rel = 1'b1;
		nxt_sda_rel = sda_oe_n_ff;
		case (st_ff)
			S_START: begin
				nxt_scl_rel = ph_ff[0] ^ ph_ff[1];
				if (ph_ff != 2'h0) begin
					nxt_sda_rel = !ph_ff[1];
				end
			end
			S_BIT: begin
				nxt_scl_rel = ph_ff[1];
				if (ph_ff != 2'h0) begin
					if (bit_ff != `TSR_ACK_BIT) begin
						nxt_sda_rel = host_rx || sh_ff[7];
					end else begin
						nxt_sda_rel = !host_rx || last_byte;
					end
				end
			end
			S_STOP: begin
				nxt_scl_rel = ph_ff[1];
				if (ph_ff != 2'h0) begin
					nxt_sda_rel = (ph_ff == 2'h3);
				end
			end
			default: nxt_sda_rel = 1'b1;
		endcase
	end

	// open drain: the pins are only ever pulled low or released
	always_ff @(posedge core_clk) begin
		if (reset) begin
			scl_oe_n_ff <= 1'b1;
			sda_oe_n_ff <= 1'b1;
			pin_lvl_ff <= 1'b0;
		end else begin
			scl_oe_n_ff <= nxt_scl_rel;
			sda_oe_n_ff <= nxt_sda_rel;
			pin_lvl_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transfer engine
	always_ff @(posedge core_clk) begin
		if (reset) begin
			st_ff <= S_IDLE;
			ph_ff <= 2'h0;
			bit_ff <= 4'h0;
			byte_ff <= 2'h0;
			tot_ff <= 3'h0;
			sh_ff <= 8'hFF;
			rd_ff <= 1'b0;
			pend_rd_ff <= 1'b0;
			nak_ff <= 1'b0;
			ev_nack_ff <= 1'b0;
			rdata_ff <= 16'h0000;
		end else begin
			ev_nack_ff <= 1'b0;
			case (st_ff)
				S_IDLE: if (go_ff) begin
					st_ff <= S_START;
					ph_ff <= 2'h0;
					byte_ff <= 2'h0;
					rdata_ff <= 16'h0000;
					rd_ff <= (op_ff == TSR_OP_READ) && !setptr_ff;
					pend_rd_ff <= (op_ff == TSR_OP_READ) && setptr_ff;
					tot_ff <= part_len((op_ff == TSR_OP_READ) && !setptr_ff,
						op_ff, len_ff);
				end
				S_START: if (tick) begin
					ph_ff <= ph_ff + 2'h1;
					if (ph_ff == 2'h3) begin
						st_ff <= S_BIT;
						bit_ff <= 4'h0;
						sh_ff <= byte_of(2'h0, rd_ff, sel_ff, ptr_ff,
							wdata_ff);
					end
				end
				S_BIT: if (tick) begin
					ph_ff <= ph_ff + 2'h1;
					if (ph_ff == 2'h2) begin
						if (bit_ff == `TSR_ACK_BIT) begin
							nak_ff <= sda_s && !host_rx;
						end else if (host_rx) begin
							sh_ff <= {sh_ff[6:0], sda_s};
						end
					end
					if (ph_ff == 2'h3) begin
						if (bit_ff != `TSR_ACK_BIT) begin
							bit_ff <= bit_ff + 4'h1;
							if (!host_rx) begin
								sh_ff <= {sh_ff[6:0], 1'b1};
							end
						end else begin
							if (host_rx) begin
								rdata_ff <= {rdata_ff[7:0], sh_ff};
							end
							if (nak_ff) begin
								// refused byte: give up, skip any read
								ev_nack_ff <= 1'b1;
								pend_rd_ff <= 1'b0;
								st_ff <= S_STOP;
							end else if (last_byte) begin
								st_ff <= S_STOP;
							end else begin
								byte_ff <= byte_ff + 2'h1;
								bit_ff <= 4'h0;
								sh_ff <= byte_of(byte_ff + 2'h1, rd_ff, sel_ff,
									ptr_ff, wdata_ff);
							end
						end
					end
				end
				S_STOP: if (tick) begin
					ph_ff <= ph_ff + 2'h1;
					if (ph_ff == 2'h3) begin
						if (pend_rd_ff) begin
							// reading needs a fresh start after the pointer
							st_ff <= S_START;
							rd_ff <= 1'b1;
							pend_rd_ff <= 1'b0;
							byte_ff <= 2'h0;
							tot_ff <= part_len(1'b1, op_ff, len_ff);
						end else begin
							st_ff <= S_DONE;
						end
					end
				end
				S_DONE: st_ff <= S_IDLE;
				default: st_ff <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	property p_start_edge;
		($fell(sda_oe_n_ff) && st_ff == S_START) |-> scl_oe_n_ff;
	endproperty
	a_start_edge: assert property (p_start_edge)
		else $error("start edge not under high clock");

	property p_stop_edge;
		($rose(sda_oe_n_ff) && $past(st_ff) == S_STOP) |-> scl_oe_n_ff;
	endproperty
	a_stop_edge: assert property (p_stop_edge)
		else $error("stop edge not under high clock");

	property p_stable_high;
		(st_ff == S_BIT && scl_oe_n_ff && $past(scl_oe_n_ff))
			|-> $stable(sda_oe_n_ff);
	endproperty
	a_stable_high: assert property (p_stable_high)
		else $error("data moved while clock high");

	property p_dir_bit;
		(st_ff == S_BIT && byte_ff == 2'h0 && bit_ff == 4'h0)
			|-> sh_ff[0] == (op_ff == TSR_OP_READ && !pend_rd_ff);
	endproperty
	a_dir_bit: assert property (p_dir_bit)
		else $error("direction bit wrong");

	property p_msb_first;
		($changed(byte_ff) && st_ff == S_BIT && !rd_ff && byte_ff >= 2'h2)
			|-> sh_ff == ((byte_ff == 2'h2) ? wdata_ff[15:8] : wdata_ff[7:0]);
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("data byte order wrong");

	property p_nack_last;
		(st_ff == S_BIT && host_rx && bit_ff == `TSR_ACK_BIT && ph_ff == 2'h2)
			|-> sda_oe_n_ff == last_byte;
	endproperty
	a_nack_last: assert property (p_nack_last)
		else $error("read acknowledge wrong");

	property p_nine_bits;
		(st_ff == S_BIT && bit_ff == `TSR_ACK_BIT && ph_ff == 2'h3 && tick)
			|=> (bit_ff == 4'h0 || st_ff == S_STOP);
	endproperty
	a_nine_bits: assert property (p_nine_bits)
		else $error("byte frame not nine clocks");

	property p_dir_fixed;
		(st_ff == S_BIT && $past(st_ff) == S_BIT) |-> $stable(rd_ff);
	endproperty
	a_dir_fixed: assert property (p_dir_fixed)
		else $error("direction changed inside transfer");

	property p_ptr_len;
		(go_ff && st_ff == S_IDLE && op_ff == TSR_OP_PTR) |=> tot_ff == 3'h2;
	endproperty
	a_ptr_len: assert property (p_ptr_len)
		else $error("pointer write length wrong");

	property p_write_len;
		(go_ff && st_ff == S_IDLE && op_ff == TSR_OP_WRITE)
			|=> tot_ff == 3'h2 + {1'b0, len_ff};
	endproperty
	a_write_len: assert property (p_write_len)
		else $error("register write length wrong");

	property p_ptr_before_read;
		($fell(pend_rd_ff) && st_ff == S_START) |-> rd_ff;
	endproperty
	a_ptr_before_read: assert property (p_ptr_before_read)
		else $error("read did not follow pointer set");
endmodule
`default_nettype wire

// [tsr_dev_model.sv]
// behavioural model of the temperature sensor two-wire slave
`timescale 1ns/10ps
`default_nettype none
module tsr_dev_model #(
	parameter int TMO_CYC = 1000
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic [2:0] addr_sel,
	input wire logic [15:0] temp_val,
	output logic sda_pull_n,
	output logic [7:0] oneshot_cnt
);
	logic scl_q_ff, sda_q_ff, act_ff, mt_ff, first_ff, rd_ff, mack_ff, idx_ff;
	logic [3:0] bc_ff;
	logic [1:0] nb_ff;
	logic [2:0] ptr_ff;
	logic [7:0] sh_ff, hi_ff, cfg_ff, obuf_ff, rbyte;
	logic [15:0] hyst_ff, ovt_ff, rword;
	logic [15:0] tmo_cnt_ff;
	logic tmo;
	////////////////////////////////////////////////////////////////////////
	always_comb begin
		case (ptr_ff)
			3'h0: rword = temp_val;
			3'h1: rword = {cfg_ff, cfg_ff};
			3'h2: rword = hyst_ff;
			3'h3: rword = ovt_ff;
			default: rword = 16'h0000;
		endcase
	end
	assign rbyte = idx_ff ? rword[7:0] : rword[15:8];
	////////////////////////////////////////////////////////////////////////
	// a silent data line after a start means the master has gone away
	always_ff @(posedge clk) begin
		if (rst || !act_ff || (sda != sda_q_ff)) begin
			tmo_cnt_ff <= 16'h0000;
		end else if (!tmo) begin
			tmo_cnt_ff <= tmo_cnt_ff + 16'h0001;
		end
	end
	assign tmo = (tmo_cnt_ff == 16'(TMO_CYC - 1));
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (rst) begin
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
			act_ff <= 1'b0;
			mt_ff <= 1'b0;
			sda_pull_n <= 1'b1;
			ptr_ff <= 3'h0;
			cfg_ff <= 8'h00;
			hyst_ff <= 16'h4B00;
			ovt_ff <= 16'h5000;
			oneshot_cnt <= 8'h00;
		end else begin
			scl_q_ff <= scl;
			sda_q_ff <= sda;
			if (scl && scl_q_ff && sda_q_ff && !sda) begin
				act_ff <= 1'b1;
				mt_ff <= 1'b0;
				bc_ff <= 4'h0;
				nb_ff <= 2'h0;
				idx_ff <= 1'b0;
				sda_pull_n <= 1'b1;
			end else if (scl && scl_q_ff && !sda_q_ff && sda) begin
				act_ff <= 1'b0;
				mt_ff <= 1'b0;
				sda_pull_n <= 1'b1;
			end else if (tmo) begin
				act_ff <= 1'b0;
				mt_ff <= 1'b0;
				sda_pull_n <= 1'b1;
			end else if (act_ff && scl && !scl_q_ff) begin
				if (bc_ff < 4'h8)
					sh_ff <= {sh_ff[6:0], sda};
				else
					mack_ff <= sda;
				bc_ff <= (bc_ff == 4'h8) ? 4'h0 : bc_ff + 4'h1;
			end else if (act_ff && !scl && scl_q_ff) begin
				// pins compared live, never latched
				if (bc_ff == 4'h8 && !mt_ff) begin
					if (sh_ff[7:1] == {4'h9, addr_sel}) begin
						mt_ff <= 1'b1;
						first_ff <= 1'b1;
						rd_ff <= sh_ff[0];
						sda_pull_n <= 1'b0;
					end else begin
						act_ff <= 1'b0;
					end
				end else if (bc_ff == 4'h8 && !rd_ff) begin
					sda_pull_n <= 1'b0;
					nb_ff <= nb_ff + 2'h1;
					if (nb_ff == 2'h0)
						ptr_ff <= sh_ff[2:0];
					if (nb_ff == 2'h0 && sh_ff[2:0] == 3'h4)
						oneshot_cnt <= oneshot_cnt + 8'h01;
					if (nb_ff == 2'h1 && ptr_ff == 3'h1)
						cfg_ff <= sh_ff;
					hi_ff <= sh_ff;
					// temperature and one-shot data bytes dropped
					if (nb_ff == 2'h2 && ptr_ff == 3'h2)
						hyst_ff <= {hi_ff, sh_ff};
					if (nb_ff == 2'h2 && ptr_ff == 3'h3)
						ovt_ff <= {hi_ff, sh_ff};
				end else if (bc_ff == 4'h0 && mt_ff && rd_ff
					&& (first_ff || !mack_ff)) begin
					first_ff <= 1'b0;
					obuf_ff <= rbyte;
					idx_ff <= 1'b1;
					sda_pull_n <= rbyte[7];
				end else if (bc_ff != 4'h0 && bc_ff != 4'h8 && mt_ff
					&& rd_ff && !first_ff) begin
					// the ninth bit belongs to the master, so it is let go
					sda_pull_n <= obuf_ff[3'h7 - bc_ff[2:0]];
				end else begin
					sda_pull_n <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// [tb_top.sv]
// testbench of the sensor host against the sensor model
`timescale 1ns/10ps
`default_nettype none
`include "tsr_defines.svh"
module tb_top;
	import tsr_pkg::*;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [3:0] wb_adr_i = 4'h0;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o, rd_q, q;
	logic wb_ack_o, scl_oe_n, sda_oe_n, sda_pull_n, scl_w, sda_w;
	logic scl_lvl, sda_lvl;
	logic [2:0] addr_sel = 3'h3;
	logic [2:0] hsel = 3'h3;
	logic [15:0] temp_val = 16'h1900;
	logic [7:0] os_cnt;
	int failures = 0;
	int n_tests = 0;
	// pull-ups: a released line reads high
	assign scl_w = scl_oe_n | scl_lvl;
	assign sda_w = (sda_oe_n | sda_lvl) & sda_pull_n;
	always #2 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////////////
	tsr_host #(.QTR_CYC(4)) dut (
		.core_clk(core_clk),
		.reset(reset),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.scl_i(scl_w),
		.scl_o(scl_lvl),
		.scl_oe_n(scl_oe_n),
		.sda_i(sda_w),
		.sda_o(sda_lvl),
		.sda_oe_n(sda_oe_n)
	);
	tsr_dev_model dev (
		.clk(core_clk),
		.rst(reset),
		.scl(scl_w),
		.sda(sda_w),
		.addr_sel(addr_sel),
		.temp_val(temp_val),
		.sda_pull_n(sda_pull_n),
		.oneshot_cnt(os_cnt)
	);
	////////////////////////////////////////////////////////////////////////
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task conclude();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		rd_q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		check("wb_ack", {31'h0, wb_ack_o}, 32'h1);
	endtask
	function automatic logic [31:0] cmd(logic [1:0] op, logic [1:0] len,
		logic sp, logic [2:0] ptr);
		return {17'h0, hsel, 1'b0, ptr, 2'h0, sp, len, op, 1'b1};
	endfunction
	task run(input logic [31:0] c, input logic [15:0] wd, input logic nk);
		int n;
		n = 0;
		wb(1'b1, `TSR_ADR_WDATA, {16'h0, wd});
		wb(1'b1, `TSR_ADR_CMD, c);
		do begin
			wb(1'b0, `TSR_ADR_STATUS, 32'h0);
			n++;
		end while (rd_q[`TSR_ST_DONE] !== 1'b1 && n < 2000);
		check("status", rd_q, {29'h0, nk, 2'h2});
		wb(1'b0, `TSR_ADR_RDATA, 32'h0);
		q = rd_q;
		wb(1'b1, `TSR_ADR_STATUS, 32'h6);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		wb(1'b0, `TSR_ADR_STATUS, 32'h0);
		check("status_rst", rd_q, 32'h0);
		wb(1'b0, 4'h2, 32'h0);
		check("unmapped", rd_q, 32'h0);
		$display("test reset done");
		run(cmd(TSR_OP_READ, 2'h2, 1'b1, `TSR_PTR_HYST), 16'h0, 1'b0);
		check("hyst_rst", q, 32'h4B00);
		run(cmd(TSR_OP_READ, 2'h2, 1'b1, `TSR_PTR_OVT), 16'h0, 1'b0);
		check("ovt_rst", q, 32'h5000);
		run(cmd(TSR_OP_READ, 2'h2, 1'b1, `TSR_PTR_TEMP), 16'h0, 1'b0);
		check("temp", q, {16'h0, temp_val});
		$display("test limits done");
		// asymmetric bytes expose a swapped byte order
		run(cmd(TSR_OP_WRITE, 2'h2, 1'b0, `TSR_PTR_HYST), 16'hE720, 1'b0);
		run(cmd(TSR_OP_WRITE, 2'h2, 1'b0, `TSR_PTR_OVT), 16'h7D10, 1'b0);
		run(cmd(TSR_OP_READ, 2'h2, 1'b1, `TSR_PTR_HYST), 16'h0, 1'b0);
		check("hyst_wr", q, 32'hE720);
		run(cmd(TSR_OP_WRITE, 2'h1, 1'b0, `TSR_PTR_CONFIG), 16'hA500, 1'b0);
		run(cmd(TSR_OP_READ, 2'h1, 1'b1, `TSR_PTR_CONFIG), 16'h0, 1'b0);
		check("cfg", q, 32'hA5);
		run(cmd(TSR_OP_PTR, 2'h0, 1'b0, `TSR_PTR_OVT), 16'h0, 1'b0);
		run(cmd(TSR_OP_READ, 2'h2, 1'b0, 3'h0), 16'h0, 1'b0);
		check("ptr_only", q, 32'h7D10);
		run(cmd(TSR_OP_WRITE, 2'h2, 1'b0, `TSR_PTR_TEMP), 16'hFFFF, 1'b0);
		run(cmd(TSR_OP_READ, 2'h2, 1'b0, 3'h0), 16'h0, 1'b0);
		check("temp_ro", q, {16'h0, temp_val});
		$display("test writes done");
		run(cmd(TSR_OP_PTR, 2'h0, 1'b0, `TSR_PTR_ONESHOT), 16'h0, 1'b0);
		check("oneshot", {24'h0, os_cnt}, 32'h1);
		run(cmd(TSR_OP_WRITE, 2'h1, 1'b0, `TSR_PTR_ONESHOT), 16'h5A00, 1'b0);
		check("oneshot_d", {24'h0, os_cnt}, 32'h2);
		run(cmd(TSR_OP_READ, 2'h1, 1'b1, `TSR_PTR_CONFIG), 16'h0, 1'b0);
		check("cfg_keep", q, 32'hA5);
		// op code three falls back to a pointer set; length three clamps
		run(cmd(2'h3, 2'h0, 1'b0, `TSR_PTR_HYST), 16'h0, 1'b0);
		run(cmd(TSR_OP_READ, 2'h3, 1'b0, 3'h0), 16'h0, 1'b0);
		check("len_clamp", q, 32'hE720);
		wb(1'b0, `TSR_ADR_CMD, 32'h0);
		check("cmd_rb", rd_q, 32'h0000_3014);
		$display("test oneshot done");
		// pins move after power-up; host follows each setting
		for (int k = 0; k < 8; k++) begin
			addr_sel <= k[2:0];
			hsel = k[2:0];
			run(cmd(TSR_OP_READ, 2'h2, 1'b1, `TSR_PTR_OVT), 16'h0, 1'b0);
			check("addr", q, 32'h7D10);
		end
		hsel = 3'h1;
		run(cmd(TSR_OP_READ, 2'h2, 1'b1, `TSR_PTR_OVT), 16'h0, 1'b1);
		check("mismatch", q, 32'h0);
		$display("test address done");
		check("pin_lvl", {30'h0, scl_lvl, sda_lvl}, 32'h0);
		conclude();
	end
	initial begin
		#300000;
		failures++;
		conclude();
	end
endmodule
`default_nettype wire
